// ==== src/pgw_datapath.sv ====
// Top of the planar graphics write/read datapath with its register port.
// How it works
// RL1: Rotate write data right by rotate count.
// RL2: Rotate only in write modes 0 and 3.
// RL3: Function field: pass, AND, OR, XOR latches.
// RL4: Every memory read reloads four plane latches.
// RL5: Read mode 0 returns selected plane byte.
// RL6: Odd/even ignores select bit 0; quad both.
// RL7: Mode field selects write; words per byte.
// RL8: Mode 0 writes rotated data or fill.
// RL9: Mode 1 writes latches, ignores processor data.
// RL10: Mode 2 low data bits colour masked pixels.
// RL11: Mode 3 masks rotated data, writes fill.
// RL12: Read mode bit picks plane or compare.
// RL13: Odd/even steers even/odd addresses to plane pairs.
// RL14: Shift mode sets video load pattern.
// RL15: Without per-character reload, shift registers chain.
// RL16: Software keeps upper shift bit clear for 8-bit.
// RL17: Chained mode swaps A0, A0 picks pair.
// RL18: Map field decodes the host window.
// RL19: Ignore bits exclude planes from compare.
// RL20: Bit mask keeps latched bits where zero.
// RL21: Software reads, sets mask, then writes.
// RL22: Data port reaches register chosen by index.
// RL23: Index is four bits, upper bits reserved.
// RL24: Enabled fill writes all ones or zeros.
// RL25: Compare match returns one, mismatch zero.
// RL26: Reserved bits ignore writes, read zero.
// RL27: All control registers clear on reset.
`timescale 1ns/10ps
module pgw_datapath (
  input  wire logic        CLK,             // System clock, 100 MHz.
  input  wire logic        SYS_RST,         // Synchronous reset, active high.
  input  wire logic        IO_WR,           // Register port write strobe.
  input  wire logic        IO_RD,           // Register port read strobe.
  input  wire logic        IO_DATA_SEL,     // 1 selects data port, 0 index port.
  input  wire logic [7:0]  IO_WDATA,        // Register port write data.
  output logic      [7:0]  IO_RDATA,        // Register port read data.
  input  wire logic        MEM_WR,          // Host memory write request.
  input  wire logic        MEM_RD,          // Host memory read request.
  input  wire logic [19:0] MEM_ADDR,        // Host byte address of lane 0.
  input  wire logic [1:0]  MEM_BE,          // Host byte enables.
  input  wire logic [15:0] MEM_WDATA,       // Host write data.
  output logic             MEM_HIT,         // Address lies in the window.
  output logic             MEM_BUSY,        // Read in progress, requests ignored.
  output logic             MEM_ACK,         // Access done, one-cycle pulse.
  output logic      [15:0] MEM_RDATA,       // Host read data.
  input  wire logic        QUAD_MODE,       // Sequencer quad plane mode.
  output logic      [31:0] DM_ADDR,         // Plane address per lane.
  output logic             DM_RD,           // Display memory read pulse.
  output logic      [7:0]  DM_WE,           // Plane write enables per lane.
  output logic      [63:0] DM_WDATA,        // Plane write data per lane.
  input  wire logic [63:0] DM_RDATA,        // Plane read data per lane.
  input  wire logic        VID_LOAD,        // Load shift registers from planes.
  input  wire logic        VID_SHIFT,       // Shift step enable pulse.
  input  wire logic        VID_RELOAD_ALL,  // Reload every character clock.
  input  wire logic        VID_WIDE8,       // 8-bit video path enabled.
  input  wire logic [31:0] VID_PLANE_DATA,  // Plane bytes for the video load.
  output logic      [3:0]  VID_PIX,         // 4-bit pixel from the shifters.
  output logic      [7:0]  VID_PIX8         // 8-bit pixel from the shifters.
);

  // All state of the block.
  typedef struct packed {
    pgw_pkg::pgw_fsm_t st;
    logic [8:0][7:0]   regs;
    logic [3:0]        idx;
    logic [3:0][7:0]   lat;
    logic [16:0]       off;
    logic [1:0]        be;
    logic              dm_rd;
    logic [7:0]        dm_we;
    logic [1:0][15:0]  dm_addr;
    logic [1:0][31:0]  dm_wdata;
    logic [15:0]       mem_rdata;
    logic              mem_ack;
    logic [7:0]        io_rdata;
    logic [3:0][7:0]   sh;
  } pgw_state_t;

  pgw_state_t            s_r;
  pgw_state_t            s_nxt;
  logic [16:0]           woff;
  logic [16:0]           cur_off;
  logic [7:0]            rd_reg;
  logic                  oesel;
  logic                  chain;
  logic [1:0]            map;
  logic [1:0]            shm;
  logic [1:0][16:0]      lane_off;
  logic [1:0][15:0]      lane_addr;
  logic [1:0][3:0]       plane_en;
  logic [1:0][1:0]       rd_plane;
  logic [1:0][3:0][7:0]  lane_wdat;
  logic [1:0][7:0]       lane_rbyte;
  logic [3:0]            shin1;
  logic [3:0][1:0]       shin2;

  // Register fields used by the datapath.
  assign map   = s_r.regs[pgw_pkg::IDX_MAP_MISC][pgw_pkg::MAP_LSB +: 2];
  assign chain = s_r.regs[pgw_pkg::IDX_MAP_MISC][pgw_pkg::CHAIN_BIT];
  assign oesel = s_r.regs[pgw_pkg::IDX_MODE_CTRL][pgw_pkg::OE_BIT] | chain;
  assign shm   = s_r.regs[pgw_pkg::IDX_MODE_CTRL][pgw_pkg::SHM_LSB +: 2];

  // Host window decode; the offset is relative to the window base.
  always_comb begin
    unique case (map)                                                    // [RL18]
      pgw_pkg::MAP_128K: begin
        MEM_HIT = (MEM_ADDR >= pgw_pkg::WIN_A0) && (MEM_ADDR <= pgw_pkg::WIN_BF);
        woff    = 17'(MEM_ADDR - pgw_pkg::WIN_A0);
      end
      pgw_pkg::MAP_64K: begin
        MEM_HIT = (MEM_ADDR >= pgw_pkg::WIN_A0) && (MEM_ADDR <= pgw_pkg::WIN_AF);
        woff    = 17'(MEM_ADDR - pgw_pkg::WIN_A0);
      end
      pgw_pkg::MAP_LO32: begin
        MEM_HIT = (MEM_ADDR >= pgw_pkg::WIN_B0) && (MEM_ADDR <= pgw_pkg::WIN_B7);
        woff    = 17'(MEM_ADDR - pgw_pkg::WIN_B0);
      end
      pgw_pkg::MAP_HI32: begin
        MEM_HIT = (MEM_ADDR >= pgw_pkg::WIN_B8) && (MEM_ADDR <= pgw_pkg::WIN_BF);
        woff    = 17'(MEM_ADDR - pgw_pkg::WIN_B8);
      end
    endcase
  end

  // The request is live while idle, and held from the capture while a read runs.
  assign cur_off = (s_r.st == pgw_pkg::PGW_IDLE) ? woff : s_r.off;

  // Reserved index values and reserved bits read as zero.
  assign rd_reg = (s_r.idx <= pgw_pkg::IDX_LAST) ? s_r.regs[s_r.idx] : 8'h00; // [RL26]

  // Both byte lanes run the same operation on their own byte.
  genvar l;
  generate
    for (l = 0; l < 2; l++) begin : g_lane
      assign lane_off[l] = 17'(cur_off + 17'(l));
      // Chained mode moves a high offset bit into A0 so planes pairs share space.
      assign lane_addr[l] = chain ? {lane_off[l][15:1], lane_off[l][16]}
                                  : lane_off[l][15:0];                   // [RL17]
      assign plane_en[l]  = !oesel ? 4'b1111 :
                            (lane_off[l][0] ? 4'b1010 : 4'b0101);        // [RL13] [RL17]
      assign rd_plane[l]  = QUAD_MODE ? lane_off[l][1:0] :
                            oesel ? {s_r.regs[pgw_pkg::IDX_READ_PLANE][1], lane_off[l][0]} :
                            s_r.regs[pgw_pkg::IDX_READ_PLANE][pgw_pkg::RPS_LSB +: 2]; // [RL6]

      pgw_lane u_lane (
        .cpu_byte (MEM_WDATA[8*l +: 8]),                                 // [RL7]
        .lat      (s_r.lat),
        .pdat     (DM_RDATA[32*l +: 32]),
        .fill_val (s_r.regs[pgw_pkg::IDX_FILL_VALUE][3:0]),
        .fill_en  (s_r.regs[pgw_pkg::IDX_FILL_ENABLE][3:0]),
        .cmp_col  (s_r.regs[pgw_pkg::IDX_CMP_COLOUR][3:0]),
        .cmp_care (s_r.regs[pgw_pkg::IDX_CMP_IGNORE][3:0]),
        .rot_cnt  (s_r.regs[pgw_pkg::IDX_ROT_FUNC][pgw_pkg::ROT_LSB +: 3]),
        .func     (s_r.regs[pgw_pkg::IDX_ROT_FUNC][pgw_pkg::FN_LSB +: 2]),
        .wmode    (s_r.regs[pgw_pkg::IDX_MODE_CTRL][pgw_pkg::WM_LSB +: 2]),
        .rmode    (s_r.regs[pgw_pkg::IDX_MODE_CTRL][pgw_pkg::RDM_BIT]),
        .bmask    (s_r.regs[pgw_pkg::IDX_BIT_MASK]),
        .rd_plane (rd_plane[l]),
        .wdat     (lane_wdat[l]),
        .rbyte    (lane_rbyte[l])
      );
    end
  endgenerate

  // Builds the four shift register loads from the plane bytes for a shift mode.
  function automatic logic [3:0][7:0] load_pat(input logic [1:0] mode,
                                              input logic [3:0][7:0] pl);
    logic [3:0][7:0] r;
    int              pa;
    int              j;
    r = '0;
    for (int k = 0; k < 4; k++) begin
      pa = (k >= 2) ? 2 : 0;
      j  = k % 2;
      for (int i = 0; i < 4; i++) begin
        if (mode == pgw_pkg::SHM_PLANAR) begin
          r[k][2*i]   = pl[k][2*i];
          r[k][2*i+1] = pl[k][2*i+1];
        end else if (mode == pgw_pkg::SHM_PAIRS) begin
          r[k][4+i] = pl[pa][2*i+j];
          r[k][i]   = pl[pa+1][2*i+j];
        end else begin
          r[k][7-2*i] = pl[i][k+4];
          r[k][6-2*i] = pl[i][k];
        end
      end
    end
    return r;
  endfunction

  // Data shifted into each register: the next one up when chained, else zero.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (!VID_RELOAD_ALL && k < 3) begin                                // [RL15]
        shin1[k] = s_r.sh[k+1][7];
        shin2[k] = s_r.sh[k+1][7:6];
      end else begin
        shin1[k] = 1'b0;
        shin2[k] = 2'b00;
      end
    end
  end

  // Next-state logic for the register port, the access sequencer and the shifters.
  always_comb begin
    s_nxt         = s_r;
    s_nxt.mem_ack = 1'b0;
    s_nxt.dm_rd   = 1'b0;
    s_nxt.dm_we   = 8'h00;

    // Index port keeps four bits; the upper bits are dropped.
    if (IO_WR && !IO_DATA_SEL) begin
      s_nxt.idx = IO_WDATA[3:0];                                         // [RL23]
    end
    // Data port writes the indexed register, reserved bits held at zero.
    if (IO_WR && IO_DATA_SEL && s_r.idx <= pgw_pkg::IDX_LAST) begin
      s_nxt.regs[s_r.idx] = IO_WDATA & pgw_pkg::REG_WMASK[s_r.idx];      // [RL22] [RL26]
    end
    if (IO_RD) begin
      s_nxt.io_rdata = IO_DATA_SEL ? rd_reg : {4'h0, s_r.idx};           // [RL22]
    end

    // Host access sequencer; a write finishes at once, a read waits on memory.
    unique case (s_r.st)
      pgw_pkg::PGW_IDLE: begin
        if (MEM_RD && MEM_HIT) begin
          s_nxt.dm_rd   = 1'b1;
          s_nxt.dm_addr = lane_addr;
          s_nxt.off     = woff;
          s_nxt.be      = MEM_BE;
          s_nxt.st      = pgw_pkg::PGW_RD_WAIT;
        end else if (MEM_WR && MEM_HIT) begin
          for (int k = 0; k < 2; k++) begin
            s_nxt.dm_we[4*k +: 4] = plane_en[k] & {4{MEM_BE[k]}};        // [RL7] [RL13]
          end
          s_nxt.dm_wdata = lane_wdat;
          s_nxt.dm_addr  = lane_addr;
          s_nxt.mem_ack  = 1'b1;
        end
      end
      pgw_pkg::PGW_RD_WAIT: begin
        s_nxt.st = pgw_pkg::PGW_RD_CAP;
      end
      pgw_pkg::PGW_RD_CAP: begin
        // Latches follow the lowest enabled lane so a byte read refreshes them.
        s_nxt.lat       = s_r.be[0] ? DM_RDATA[31:0] : DM_RDATA[63:32];   // [RL4]
        s_nxt.mem_rdata = {lane_rbyte[1], lane_rbyte[0]};                // [RL12]
        s_nxt.mem_ack   = 1'b1;
        s_nxt.st        = pgw_pkg::PGW_IDLE;
      end
    endcase

    // Video shifters; the 8-bit path takes two bits per plane each step.
    if (VID_LOAD) begin
      s_nxt.sh = load_pat(shm, VID_PLANE_DATA);                          // [RL14]
    end else if (VID_SHIFT) begin
      for (int k = 0; k < 4; k++) begin
        if (VID_WIDE8) begin
          s_nxt.sh[k] = {s_r.sh[k][5:0], shin2[k]};
        end else begin
          s_nxt.sh[k] = {s_r.sh[k][6:0], shin1[k]};                      // [RL15]
        end
      end
    end
  end

  // State register; every control register clears on reset.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_r <= '0;                                                         // [RL27]
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign IO_RDATA  = s_r.io_rdata;
  assign MEM_BUSY  = (s_r.st != pgw_pkg::PGW_IDLE);
  assign MEM_ACK   = s_r.mem_ack;
  assign MEM_RDATA = s_r.mem_rdata;
  assign DM_ADDR   = s_r.dm_addr;
  assign DM_RD     = s_r.dm_rd;
  assign DM_WE     = s_r.dm_we;
  assign DM_WDATA  = s_r.dm_wdata;
  assign VID_PIX   = {s_r.sh[3][7], s_r.sh[2][7], s_r.sh[1][7], s_r.sh[0][7]};
  // The 8-bit pixel is two adjacent bit positions of planes 3 to 0.
  assign VID_PIX8  = {s_r.sh[3][7], s_r.sh[2][7], s_r.sh[1][7], s_r.sh[0][7],
                      s_r.sh[3][6], s_r.sh[2][6], s_r.sh[1][6], s_r.sh[0][6]}; // [RL16]

endmodule

// ==== src/pgw_pkg.sv ====
// Shared constants and types of the planar graphics write/read datapath.
package pgw_pkg;

  // Register indices behind the data port.
  localparam logic [3:0] IDX_FILL_VALUE  = 4'h0;
  localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
  localparam logic [3:0] IDX_CMP_COLOUR  = 4'h2;
  localparam logic [3:0] IDX_ROT_FUNC    = 4'h3;
  localparam logic [3:0] IDX_READ_PLANE  = 4'h4;
  localparam logic [3:0] IDX_MODE_CTRL   = 4'h5;
  localparam logic [3:0] IDX_MAP_MISC    = 4'h6;
  localparam logic [3:0] IDX_CMP_IGNORE  = 4'h7;
  localparam logic [3:0] IDX_BIT_MASK    = 4'h8;
  localparam logic [3:0] IDX_LAST        = 4'h8;

  // Reset value of every register and writable bits per index (index 8 first).
  localparam logic [7:0]      REG_RST   = 8'h00;
  localparam logic [8:0][7:0] REG_WMASK = {8'hFF, 8'h0F, 8'h0F, 8'h7B, 8'h03,
                                           8'h1F, 8'h0F, 8'h0F, 8'h0F};

  // Field positions.
  localparam int ROT_LSB   = 0;
  localparam int FN_LSB    = 3;
  localparam int RPS_LSB   = 0;
  localparam int WM_LSB    = 0;
  localparam int RDM_BIT   = 3;
  localparam int OE_BIT    = 4;
  localparam int SHM_LSB   = 5;
  localparam int CHAIN_BIT = 1;
  localparam int MAP_LSB   = 2;

  // Write modes, logic functions, shift modes.
  localparam logic [1:0] WM0 = 2'b00;
  localparam logic [1:0] WM1 = 2'b01;
  localparam logic [1:0] WM2 = 2'b10;
  localparam logic [1:0] WM3 = 2'b11;
  localparam logic [1:0] FN_PASS = 2'b00;
  localparam logic [1:0] FN_AND  = 2'b01;
  localparam logic [1:0] FN_OR   = 2'b10;
  localparam logic [1:0] FN_XOR  = 2'b11;
  localparam logic [1:0] SHM_PLANAR = 2'b00;
  localparam logic [1:0] SHM_PAIRS  = 2'b01;

  // Host memory window decode.
  localparam logic [1:0]  MAP_128K = 2'b00;
  localparam logic [1:0]  MAP_64K  = 2'b01;
  localparam logic [1:0]  MAP_LO32 = 2'b10;
  localparam logic [1:0]  MAP_HI32 = 2'b11;
  localparam logic [19:0] WIN_A0   = 20'hA_0000;
  localparam logic [19:0] WIN_AF   = 20'hA_FFFF;
  localparam logic [19:0] WIN_B0   = 20'hB_0000;
  localparam logic [19:0] WIN_B7   = 20'hB_7FFF;
  localparam logic [19:0] WIN_B8   = 20'hB_8000;
  localparam logic [19:0] WIN_BF   = 20'hB_FFFF;

  typedef enum logic [1:0] {PGW_IDLE, PGW_RD_WAIT, PGW_RD_CAP} pgw_fsm_t;

endpackage

// ==== src/pgw_lane.sv ====
// One byte lane of the plane write and read logic, purely combinational.
`timescale 1ns/10ps
module pgw_lane (
  input  wire logic [7:0]      cpu_byte,  // Processor byte of this lane.
  input  wire logic [3:0][7:0] lat,       // Processor latches, one per plane.
  input  wire logic [3:0][7:0] pdat,      // Plane bytes just read.
  input  wire logic [3:0]      fill_val,  // Per-plane fill value.
  input  wire logic [3:0]      fill_en,   // Per-plane fill enable.
  input  wire logic [3:0]      cmp_col,   // Compare reference colour.
  input  wire logic [3:0]      cmp_care,  // Planes taking part in compare.
  input  wire logic [2:0]      rot_cnt,   // Rotate count.
  input  wire logic [1:0]      func,      // Logic function.
  input  wire logic [1:0]      wmode,     // Write mode.
  input  wire logic            rmode,     // Read mode.
  input  wire logic [7:0]      bmask,     // Write bit mask.
  input  wire logic [1:0]      rd_plane,  // Plane returned in read mode 0.
  output logic      [3:0][7:0] wdat,      // Data for each plane.
  output logic      [7:0]      rbyte      // Byte returned to the processor.
);

  logic [15:0]     dbl;
  logic [7:0]      rot;
  logic [7:0]      msk;
  logic [7:0]      src;
  logic [7:0]      res;
  logic [7:0]      match;

  // Applies the selected logic function against a latch byte.
  function automatic logic [7:0] alu(input logic [1:0] fn, input logic [7:0] d,
                                     input logic [7:0] l);
    unique case (fn)
      pgw_pkg::FN_PASS: alu = d;
      pgw_pkg::FN_AND:  alu = d & l;
      pgw_pkg::FN_OR:   alu = d | l;
      pgw_pkg::FN_XOR:  alu = d ^ l;
    endcase
  endfunction

  // Write path: rotate, pick a source, apply the function, then the bit mask.
  always_comb begin
    src  = 8'h00;
    res  = 8'h00;
    dbl  = {cpu_byte, cpu_byte} >> rot_cnt;                              // [RL1]
    rot  = (wmode == pgw_pkg::WM0 || wmode == pgw_pkg::WM3) ? dbl[7:0] : cpu_byte; // [RL2]
    msk  = (wmode == pgw_pkg::WM3) ? (rot & bmask) : bmask;              // [RL11]
    for (int p = 0; p < 4; p++) begin
      unique case (wmode)
        pgw_pkg::WM0: src = fill_en[p] ? {8{fill_val[p]}} : rot;         // [RL8] [RL24]
        pgw_pkg::WM1: src = lat[p];                                      // [RL9]
        pgw_pkg::WM2: src = {8{cpu_byte[p]}};                            // [RL10]
        pgw_pkg::WM3: src = {8{fill_val[p]}};                            // [RL11]
      endcase
      // Mode 1 copies the latches untouched, so the function is bypassed.
      res     = (wmode == pgw_pkg::WM1) ? src : alu(func, src, lat[p]);  // [RL3]
      wdat[p] = (res & msk) | (lat[p] & ~msk);                           // [RL20]
    end
  end

  // Read path: one plane, or a per-pixel colour match over the cared-for planes.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      match[i] = &(~({pdat[3][i], pdat[2][i], pdat[1][i], pdat[0][i]} ^ cmp_col)
                   | ~cmp_care);                                         // [RL19] [RL25]
    end
    rbyte = rmode ? match : pdat[rd_plane];                              // [RL12] [RL5]
  end

endmodule

// ==== test/pgw_datapath_asserts.sv ====
// Port-level checks on the planar graphics write/read datapath.
`timescale 1ns/10ps
module pgw_datapath_asserts (
  input wire logic       CLK,        // Clock.
  input wire logic       SYS_RST,    // Reset.
  input wire logic       IO_RD,      // Port read.
  input wire logic [7:0] IO_RDATA,   // Port data.
  input wire logic       MEM_WR,     // Write request.
  input wire logic       MEM_RD,     // Read request.
  input wire logic       MEM_HIT,    // Window hit.
  input wire logic       MEM_BUSY,   // Read busy.
  input wire logic       MEM_ACK,    // Done pulse.
  input wire logic       DM_RD,      // Plane read.
  input wire logic [7:0] DM_WE,      // Plane writes.
  input wire logic       VID_SHIFT,  // Shifter step.
  input wire logic       VID_LOAD,   // Shifter load.
  input wire logic       VID_WIDE8,  // Wide path.
  input wire logic [3:0] VID_PIX,    // Pixel.
  input wire logic [7:0] VID_PIX8    // Wide pixel.
);
  // One clock domain; a reset abandons every check in flight.
  default clocking dclk @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  logic rd_go;
  logic wr_go;
  // Accepted requests; a read wins over a write offered in the same cycle.
  assign rd_go = MEM_RD && MEM_HIT && !MEM_BUSY;
  assign wr_go = MEM_WR && !MEM_RD && MEM_HIT && !MEM_BUSY;

  a_write_ack_next: assert property (wr_go |=> MEM_ACK)
    else $error("Write not answered in the next cycle.");
  a_read_ack_three: assert property (rd_go |=> !MEM_ACK [*2] ##1 MEM_ACK)
    else $error("Read answer not three cycles after request.");
  a_read_busy_span: assert property (rd_go |=> MEM_BUSY [*2] ##1 !MEM_BUSY)
    else $error("Busy window of a read is wrong.");
  a_plane_read_pulse: assert property (rd_go |=> DM_RD ##1 !DM_RD)
    else $error("Plane read pulse missing or too long.");
  a_miss_dropped: assert property ((MEM_WR || MEM_RD) && !MEM_HIT && !MEM_BUSY
                                   |=> !MEM_ACK && DM_WE == 8'h00)
    else $error("Access outside the window was carried out.");
  a_we_with_ack: assert property (DM_WE != 8'h00 |-> MEM_ACK)
    else $error("Plane write without a host answer.");
  a_rdata_hold: assert property (!IO_RD |=> $stable(IO_RDATA))
    else $error("Port read data changed without a read.");
  a_shift_step: assert property (VID_SHIFT && !VID_LOAD && !VID_WIDE8
                                 |=> VID_PIX == $past(VID_PIX8[3:0]))
    else $error("Shift step did not advance the pixel bits.");
endmodule

bind pgw_datapath pgw_datapath_asserts pgw_datapath_asserts_inst (.*);

// ==== test/pgw_dmem_model.sv ====
// Behavioural display memory with four planes and a one-cycle read.
`timescale 1ns/10ps
module pgw_dmem_model (
  input  wire logic        CLK,       // Clock.
  input  wire logic [31:0] DM_ADDR,   // Address per lane.
  input  wire logic        DM_RD,     // Read pulse.
  input  wire logic [7:0]  DM_WE,     // Lane and plane enables.
  input  wire logic [63:0] DM_WDATA,  // Write data.
  output logic      [63:0] DM_RDATA   // Read data.
);
  logic [7:0]  mem_r [4][256];
  logic [63:0] rd_r;
  logic        vld_r;
  // Both lanes share the planes; only the low address byte is kept, enough here.
  always_ff @(posedge CLK) begin
    vld_r <= DM_RD;
    for (int i = 0; i < 8; i++) begin
      if (DM_WE[i]) begin
        mem_r[i % 4][DM_ADDR[16 * (i / 4) +: 8]] <= DM_WDATA[8 * i +: 8];
      end
      if (DM_RD) begin
        rd_r[8 * i +: 8] <= mem_r[i % 4][DM_ADDR[16 * (i / 4) +: 8]];
      end
    end
  end
  // Data stands one cycle only; afterwards it is inverted so a late capture fails.
  assign DM_RDATA = vld_r ? rd_r : ~rd_r;
endmodule

// ==== test/test_pgw_datapath.sv ====
// Self-checking bench for the planar graphics write/read datapath.
`timescale 1ns/10ps
module test_pgw_datapath;
  logic        CLK, SYS_RST, IO_WR, IO_RD, IO_DATA_SEL, MEM_WR, MEM_RD, MEM_HIT, MEM_BUSY;
  logic        MEM_ACK, QUAD_MODE, DM_RD, VID_LOAD, VID_SHIFT, VID_RELOAD_ALL, VID_WIDE8;
  logic [7:0]  IO_WDATA, IO_RDATA, DM_WE, VID_PIX8, we_seen;
  logic [1:0]  MEM_BE;
  logic [3:0]  VID_PIX;
  logic [19:0] MEM_ADDR;
  logic [15:0] MEM_WDATA, MEM_RDATA;
  logic [31:0] DM_ADDR, VID_PLANE_DATA;
  logic [63:0] DM_WDATA, DM_RDATA;
  int          n_errors, n_tests, cycles;
  // Writes: fill value, fill enable, rotate and function, mode, mask, data, planes 3..0.
  localparam logic [79:0] WT [10] = '{
    80'h0000_0300_FF81_3030_3030, 80'h0503_0300_FF81_3030_00FF,
    80'h0503_0301_FF00_3030_00FF, 80'h0000_0000_FF0F_0F0F_0F0F,
    80'h0000_0800_FF0F_0000_000F, 80'h0000_1000_FF0F_3F3F_0FFF,
    80'h0000_1800_FF0F_3F3F_0FF0, 80'h0000_0000_C355_7171_417D,
    80'h000F_0102_0F06_303F_0FF0, 80'h0500_0103_FF06_3033_00FF};
  localparam logic [19:0] ADR [8] = '{20'h9_FFFF, 20'hA_0000, 20'hA_FFFF, 20'hB_0000,
                                      20'hB_7FFF, 20'hB_8000, 20'hB_FFFF, 20'hC_0000};
  localparam logic [7:0]  HIT [4] = '{8'h7E, 8'h60, 8'h18, 8'h06};

  pgw_datapath pgw_datapath_inst (.*);
  pgw_dmem_model pgw_dmem_model_inst (.*);

  // Clock, and a cycle ceiling so a hang still reaches the report.
  initial begin
    CLK = 0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rst();
    SYS_RST = 1;
    repeat (4) @(negedge CLK);
    SYS_RST = 0;
  endtask
  // Register port cycle; strobes are dropped at the following falling edge.
  task automatic io(input logic rd, input logic sel, input logic [7:0] d);
    @(negedge CLK);
    {IO_WR, IO_RD, IO_DATA_SEL, IO_WDATA} = {!rd, rd, sel, d};
    @(negedge CLK);
    {IO_WR, IO_RD} = 2'b00;
  endtask
  task automatic wreg(input logic [3:0] idx, input logic [7:0] v);
    io(0, 0, {4'hF, idx});
    io(0, 1, v);
  endtask
  task automatic rreg(input logic [3:0] idx, input logic [7:0] exp);
    io(0, 0, {4'hF, idx});
    io(1, 0, 8'h00);
    chk(IO_RDATA, {4'h0, idx});
    io(1, 1, 8'h00);
    chk(IO_RDATA, exp);
  endtask
  // Host access; waits a bounded time for the answer and records the plane enables.
  task automatic macc(input logic rd, input logic [19:0] a, input logic [1:0] be,
                      input logic [15:0] d, input logic ack);
    @(negedge CLK);
    {MEM_WR, MEM_RD, MEM_ADDR, MEM_BE, MEM_WDATA} = {!rd, rd, a, be, d};
    @(negedge CLK);
    {MEM_WR, MEM_RD} = 2'b00;
    for (int i = 0; i < 4 && MEM_ACK !== 1'b1; i++) @(negedge CLK);
    we_seen = DM_WE;
    chk(MEM_ACK, ack);
  endtask
  task automatic vid(input logic [1:0] sm, input logic rel, input int n,
                     input logic [3:0] exp);
    wreg(4'h5, {1'b0, sm, 5'h00});
    @(negedge CLK);
    {VID_RELOAD_ALL, VID_LOAD} = {rel, 1'b1};
    @(negedge CLK);
    VID_LOAD = 0;
    repeat (n) begin
      VID_SHIFT = 1;
      @(negedge CLK);
    end
    VID_SHIFT = 0;
    chk(VID_PIX, exp);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence; the wide video path is on only for the last two checks, with shift mode 00.
  initial begin
    {IO_WR, IO_RD, IO_DATA_SEL, IO_WDATA, MEM_WR, MEM_RD, MEM_ADDR, MEM_BE, MEM_WDATA} = '0;
    {QUAD_MODE, VID_LOAD, VID_SHIFT, VID_RELOAD_ALL, VID_WIDE8} = '0;
    VID_PLANE_DATA = 32'h0180_FF00;
    rst();
    chk({IO_RDATA, MEM_RDATA, VID_PIX8, DM_WE}, 64'h0);
    for (int i = 0; i < 10; i++) begin
      rreg(4'(i), 8'h00);
      wreg(4'(i), 8'hFF);
      rreg(4'(i), (i < 9) ? pgw_pkg::REG_WMASK[i] : 8'h00);
    end
    rst();
    for (int i = 0; i < 10; i++) begin
      if (i == 2) begin
        for (int p = 0; p < 4; p++) begin
          wreg(4'h4, 8'(p));
          macc(1, 20'hA_0010, 2'b01, 16'h0000, 1);
          chk(MEM_RDATA[7:0], WT[1][8 * p +: 8]);
        end
      end
      wreg(4'h0, WT[i][79:72]);
      wreg(4'h1, WT[i][71:64]);
      wreg(4'h3, WT[i][63:56]);
      wreg(4'h5, WT[i][55:48]);
      wreg(4'h8, WT[i][47:40]);
      macc(0, 20'hA_0010, 2'b01, {8'h00, WT[i][39:32]}, 1);
      chk({we_seen, DM_WDATA[31:0]}, {8'h0F, WT[i][31:0]});
    end
    wreg(4'h2, 8'h05);
    wreg(4'h5, 8'h08);
    for (int c = 0; c < 2; c++) begin
      wreg(4'h7, c ? 8'h01 : 8'h0F);
      macc(1, 20'hA_0010, 2'b01, 16'h0000, 1);
      chk(MEM_RDATA[7:0], c ? 8'hFF : 8'h03);
    end
    wreg(4'h5, 8'h00);
    wreg(4'h4, 8'h03);
    QUAD_MODE = 1;
    macc(1, 20'hA_0010, 2'b01, 16'h0000, 1);
    chk(MEM_RDATA[7:0], 8'hFF);
    QUAD_MODE = 0;
    wreg(4'h3, 8'h00);
    macc(0, 20'hA_0010, 2'b11, 16'h1234, 1);
    chk(DM_WDATA, 64'h1212_1212_3434_3434);
    chk(DM_ADDR, 32'h0011_0010);
    wreg(4'h5, 8'h10);
    macc(0, 20'hA_0011, 2'b01, 16'h0000, 1);
    chk(we_seen, 8'h0A);
    // Odd/even read: select bit 0 comes from the address, so plane 3 not plane 2.
    wreg(4'h4, 8'h02);
    macc(1, 20'hA_0011, 2'b01, 16'h0000, 1);
    chk(MEM_RDATA[7:0], 8'h00);
    wreg(4'h5, 8'h00);
    wreg(4'h6, 8'h02);
    macc(0, 20'hB_0010, 2'b01, 16'h0000, 1);
    chk({we_seen, DM_ADDR[15:0]}, 24'h05_0011);
    for (int m = 0; m < 4; m++) begin
      wreg(4'h6, 8'(m << 2));
      for (int k = 0; k < 8; k++) begin
        MEM_ADDR = ADR[k];
        @(negedge CLK);
        chk(MEM_HIT, HIT[m][7 - k]);
      end
    end
    macc(0, 20'hA_0000, 2'b01, 16'h0000, 0);
    vid(2'b00, 1, 1, 4'h2);
    vid(2'b00, 1, 8, 4'h0);
    vid(2'b00, 0, 8, 4'h3);
    vid(2'b01, 1, 0, 4'h8);
    vid(2'b01, 1, 4, 4'h3);
    vid(2'b10, 1, 2, 4'hF);
    // Wide path with the upper shift bit clear: two bit positions per step.
    VID_WIDE8 = 1;
    vid(2'b00, 1, 1, 4'h2);
    chk(VID_PIX8, 8'h22);
    VID_WIDE8 = 0;
    end_sim();
  end
endmodule
